// ===== verilog/iopgc_pkg.sv
// Shared constants, types and register layout of the I/O pin group controller
package iopgc_pkg;
	// ==========================================================================
	// Geometry
	localparam int PIN_W       = 32;
	localparam int BYTE_W      = 8;
	localparam int LANES       = 4;
	localparam int SUBGRP_W    = 8;
	localparam int SAMP_W      = PIN_W / SUBGRP_W;
	localparam int FSEL_W      = 4;
	localparam int CFG_W       = 3;
	localparam int ADDR_W      = 10;
	localparam int GRP_SH      = 7;
	localparam int OFF_W       = 7;
	localparam int SYNC_STAGES = 2;
	// ==========================================================================
	// Register offsets inside one group
	localparam logic [OFF_W-1:0] OFF_DIR    = 7'h00;
	localparam logic [OFF_W-1:0] OFF_OUT    = 7'h10;
	localparam logic [OFF_W-1:0] OFF_IN     = 7'h20;
	localparam logic [OFF_W-1:0] OFF_CTRL   = 7'h24;
	localparam logic [OFF_W-1:0] OFF_PMUX   = 7'h30;
	localparam logic [OFF_W-1:0] OFF_PINCFG = 7'h40;
	localparam logic [OFF_W-1:0] OFF_END    = 7'h60;
	localparam logic [OFF_W-1:0] VIEW_CLR   = 7'h04;
	localparam logic [OFF_W-1:0] VIEW_SET   = 7'h08;
	localparam logic [OFF_W-1:0] VIEW_TGL   = 7'h0c;
	// ==========================================================================
	// Per pin configuration bit positions
	localparam int CFG_PERIPH_MUX_ENABLE = 0;
	localparam int CFG_INPUT_BUFFER_ENABLE   = 1;
	localparam int CFG_PULL_ENABLE = 2;
	// ==========================================================================
	// Local bus transfer sizes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [3:0] BE_LO     = 4'h3;
	localparam logic [3:0] BE_HI     = 4'hc;
	localparam logic [3:0] BE_ALL    = 4'hf;
	localparam logic [3:0] BE_ONE    = 4'h1;
	// ==========================================================================
	// Types
	typedef struct packed {
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [PIN_W-1:0]  wdata;
		logic [LANES-1:0]  be;
	} iopgc_req_t;
	typedef enum logic [1:0] {
		B_IDLE = 2'b00,
		B_WAIT = 2'b01,
		B_DONE = 2'b10
	} iopgc_bstate_t;
endpackage : iopgc_pkg

// ===== verilog/iopgc_top.sv
// I/O pin group controller: registers, two access ports, synchronisers and pad control
//
// Function
// - Pins grouped by up to 32, each controllable alone or together.
// - One 8/16/32-bit write atomically sets, clears or toggles chosen pins only.
// - Direction, output and input registers reachable from bridge and local bus.
// - During reset every pin is input with buffer, driver and pull off.
// - Logic keeps running whenever its clock runs, no sleep gating.
// - Local bus wins a collision; bridge access then slips one cycle.
// - Debug halt freezes nothing; there is no halt input.
// - Write protect blocks writes, except bridge accesses flagged as debugger.
// - Analog function on a pin disables its digital input, output and pull.
// - Local bus finishes each byte, halfword or word transfer in one cycle.
// - Local bus reads, writes, sets, clears, toggles direction/output; reads input.
// - Direction bit one makes the pin output, zero makes it input.
// - Output pin drives high for output bit one, low for zero.
// - Input bits come from two-stage synchronisers, optionally clocked only on demand.
// - Pin level readable whatever the pin direction.
// - Input enable zero stops sampling of that pin.
// - Mux enable hands the pin to the selected function, overriding own drive.
// - Muxed peripheral drives the pad and reads the raw pad level.
// - Register set repeats per group, with one configuration byte per pin.
// - Demand read costs two extra cycles; continuous sampling per eight pins.
// - Writing one to set, clear, toggle view sets, clears, inverts the bit.
// - Pull on a non-output pin pulls up for output bit one, down for zero.
// - Output mode forces the pull resistor off.
`timescale 1ns/100ps
module iopgc_top
	import iopgc_pkg::*;
#(
	parameter int GROUPS = 2,
	parameter int NP     = GROUPS * PIN_W
) (
	input  wire logic              clk_sys_in,
	input  wire logic              rst_n_in,
	input  wire logic              wp_in,
	input  wire logic              local_valid_in,
	input  wire logic              local_write_in,
	input  wire logic [ADDR_W-1:0] local_addr_in,
	input  wire logic [1:0]        local_size_in,
	input  wire logic [PIN_W-1:0]  local_wdata_in,
	output logic      [PIN_W-1:0]  local_rdata_out,
	input  wire logic              bridge_valid_in,
	input  wire logic              bridge_write_in,
	input  wire logic              bridge_debug_in,
	input  wire logic [ADDR_W-1:0] bridge_addr_in,
	input  wire logic [LANES-1:0]  bridge_be_in,
	input  wire logic [PIN_W-1:0]  bridge_wdata_in,
	output logic      [PIN_W-1:0]  bridge_rdata_out,
	output logic                   bridge_ready_out,
	input  wire logic [NP-1:0]     pad_level_in,
	output logic      [NP-1:0]     pad_out,
	output logic      [NP-1:0]     pad_oe_n_out,
	output logic      [NP-1:0]     pad_in_en_out,
	output logic      [NP-1:0]     pad_pull_en_out,
	output logic      [NP-1:0]     pad_pull_up_out,
	input  wire logic [NP-1:0]     periph_out_in,
	input  wire logic [NP-1:0]     periph_oe_in,
	input  wire logic [NP-1:0]     periph_analog_in,
	output logic      [NP-1:0]     periph_level_out,
	output logic      [NP*FSEL_W-1:0] periph_function_select_out
);
	// ==========================================================================
	// Storage
	logic [GROUPS-1:0][PIN_W-1:0]        dir_reg;
	logic [GROUPS-1:0][PIN_W-1:0]        out_reg;
	logic [GROUPS-1:0][PIN_W-1:0]        sync1_reg;
	logic [GROUPS-1:0][PIN_W-1:0]        in_reg;
	logic [GROUPS-1:0][SAMP_W-1:0]       ctrl_reg;
	logic [GROUPS-1:0][PIN_W*FSEL_W-1:0] pmux_reg;
	logic [NP-1:0][CFG_W-1:0]            per_pin_config_reg;
	logic [GROUPS-1:0][PIN_W*BYTE_W-1:0] cfg_bytes;
	logic [GROUPS-1:0][PIN_W-1:0]        rd_grp;
	iopgc_bstate_t                       bstate_reg;
	iopgc_bstate_t                       bstate_next;
	logic [1:0]                          cnt_reg;
	// ==========================================================================
	// Request decode
	iopgc_req_t       local_req;
	iopgc_req_t       bridge_req;
	iopgc_req_t       acc;
	logic [LANES-1:0] local_be;
	logic [OFF_W-1:0] acc_off;
	logic [ADDR_W-GRP_SH-1:0] acc_grp;
	logic [OFF_W-1:0] br_off;
	logic [ADDR_W-GRP_SH-1:0] br_grp;
	logic [PIN_W-1:0] acc_bm;
	logic [PIN_W-1:0] acc_bits;
	logic [PIN_W-1:0] rd_word;
	logic             bridge_go;
	logic             acc_go;
	logic             acc_we;
	logic             need_demand;
	logic             grp_ok;
	logic             local_ok;
	logic             wr_blocked;

	assign local_be = (local_size_in == SIZE_BYTE) ? (BE_ONE << local_addr_in[1:0]) :
		(local_size_in == SIZE_HALF) ? (local_addr_in[1] ? BE_HI : BE_LO) : BE_ALL;
	assign local_req  = '{wr: local_write_in, addr: local_addr_in,
		wdata: local_wdata_in, be: local_be};
	assign bridge_req = '{wr: bridge_write_in, addr: bridge_addr_in,
		wdata: bridge_wdata_in, be: bridge_be_in};
	assign br_off = {bridge_addr_in[GRP_SH-1:2], 2'b00};
	assign br_grp = bridge_addr_in[ADDR_W-1:GRP_SH];
	assign need_demand = !bridge_write_in && br_off == OFF_IN && 32'(br_grp) < GROUPS &&
		!(&ctrl_reg[32'(br_grp) % GROUPS]);
	assign bridge_go = bridge_valid_in && !local_valid_in &&
		(bstate_reg == B_IDLE && !need_demand ||
		bstate_reg == B_WAIT && 32'(cnt_reg) >= SYNC_STAGES - 1);
	assign acc     = local_valid_in ? local_req : bridge_req;
	assign acc_go  = local_valid_in || bridge_go;
	assign acc_off = {acc.addr[GRP_SH-1:2], 2'b00};
	assign acc_grp = acc.addr[ADDR_W-1:GRP_SH];
	assign grp_ok  = 32'(acc_grp) < GROUPS;
	assign local_ok = !local_valid_in || acc_off <= OFF_IN;
	assign wr_blocked = wp_in && !(bridge_go && bridge_debug_in);
	assign acc_we = acc_go && acc.wr && !wr_blocked && grp_ok && local_ok;
	assign acc_bits = acc.wdata & acc_bm;

	generate
		for (genvar l = 0; l < LANES; l++) begin : g_lane
			assign acc_bm[l*BYTE_W +: BYTE_W] = {BYTE_W{acc.be[l]}};
		end
	endgenerate

	// ==========================================================================
	// View update: plain write, clear, set, toggle
	function automatic logic [PIN_W-1:0] view_upd(
		input logic [PIN_W-1:0] old,
		input logic [OFF_W-1:0] base,
		input logic [OFF_W-1:0] off,
		input logic [PIN_W-1:0] bits,
		input logic [PIN_W-1:0] bm
	);
		logic [PIN_W-1:0] r;
		r = old;
		if (off == base)
			r = (old & ~bm) | bits;
		else if (off == base + VIEW_CLR)
			r = old & ~bits;
		else if (off == base + VIEW_SET)
			r = old | bits;
		else if (off == base + VIEW_TGL)
			r = old ^ bits;
		return r;
	endfunction : view_upd

	// ==========================================================================
	// Per group register set
	generate
		for (genvar g = 0; g < GROUPS; g++) begin : g_grp
			logic gwe;
			logic demand;
			assign gwe    = acc_we && 32'(acc_grp) == g;
			assign demand = (bstate_reg == B_WAIT || bstate_reg == B_IDLE && bridge_valid_in &&
				!local_valid_in && need_demand) && 32'(br_grp) == g;

			always_ff @(posedge clk_sys_in) begin
				if (!rst_n_in) begin
					dir_reg[g]  <= '0;
					out_reg[g]  <= '0;
					ctrl_reg[g] <= '0;
				end else if (gwe) begin
					dir_reg[g] <= view_upd(dir_reg[g], OFF_DIR, acc_off, acc_bits, acc_bm);
					out_reg[g] <= view_upd(out_reg[g], OFF_OUT, acc_off, acc_bits, acc_bm);
					if (acc_off == OFF_CTRL && acc.be[0])
						ctrl_reg[g] <= acc.wdata[SAMP_W-1:0];
				end
			end

			always_comb begin
				rd_grp[g] = '0;
				if (acc_off < OFF_OUT)
					rd_grp[g] = dir_reg[g];
				else if (acc_off < OFF_IN)
					rd_grp[g] = out_reg[g];
				else if (acc_off == OFF_IN)
					rd_grp[g] = in_reg[g];
				else if (acc_off == OFF_CTRL)
					rd_grp[g] = {{(PIN_W-SAMP_W){1'b0}}, ctrl_reg[g]};
				else if (acc_off >= OFF_PMUX && acc_off < OFF_PINCFG)
					rd_grp[g] = pmux_reg[g][PIN_W*acc_off[3:2] +: PIN_W];
				else if (acc_off >= OFF_PINCFG && acc_off < OFF_END)
					rd_grp[g] = cfg_bytes[g][PIN_W*(acc_off[4:2]) +: PIN_W];
			end

			for (genvar p = 0; p < PIN_W; p++) begin : g_pin
				localparam int N   = g * PIN_W + p;
				localparam int CL  = p % LANES;
				localparam int ML  = (p / 2) % LANES;
				localparam int MB  = ML * BYTE_W + (p % 2) * FSEL_W;
				localparam logic [OFF_W-1:0] CFG_OFF  = OFF_PINCFG + OFF_W'((p / LANES) * LANES);
				localparam logic [OFF_W-1:0] PMUX_OFF = OFF_PMUX + OFF_W'((p / SUBGRP_W) * LANES);
				logic [CFG_W-1:0] cfg;
				logic samp_en;
				logic muxed;
				logic analog;
				logic drive;
				assign cfg     = per_pin_config_reg[N];
				assign cfg_bytes[g][p*BYTE_W +: BYTE_W] = {{(BYTE_W-CFG_W){1'b0}}, cfg};
				assign samp_en = cfg[CFG_INPUT_BUFFER_ENABLE] && (ctrl_reg[g][p/SUBGRP_W] || demand);
				assign muxed   = cfg[CFG_PERIPH_MUX_ENABLE];
				assign analog  = muxed && periph_analog_in[N];
				assign drive   = muxed ? periph_oe_in[N] : dir_reg[g][p];

				always_ff @(posedge clk_sys_in) begin
					if (!rst_n_in) begin
						per_pin_config_reg[N] <= '0;
						pmux_reg[g][p*FSEL_W +: FSEL_W] <= '0;
					end else if (gwe) begin
						if (acc_off == CFG_OFF && acc.be[CL])
							per_pin_config_reg[N] <= acc.wdata[CL*BYTE_W +: CFG_W];
						if (acc_off == PMUX_OFF && acc.be[ML])
							pmux_reg[g][p*FSEL_W +: FSEL_W] <= acc.wdata[MB +: FSEL_W];
					end
				end

				always_ff @(posedge clk_sys_in) begin
					if (!rst_n_in) begin
						sync1_reg[g][p] <= 1'b0;
						in_reg[g][p]    <= 1'b0;
					end else if (samp_en) begin
						sync1_reg[g][p] <= pad_level_in[N];
						in_reg[g][p]    <= sync1_reg[g][p];
					end
				end

				always_ff @(posedge clk_sys_in) begin
					if (!rst_n_in) begin
						pad_oe_n_out[N]    <= 1'b1;
						pad_out[N]         <= 1'b0;
						pad_in_en_out[N]   <= 1'b0;
						pad_pull_en_out[N] <= 1'b0;
						pad_pull_up_out[N] <= 1'b0;
						periph_level_out[N] <= 1'b0;
					end else begin
						pad_oe_n_out[N]    <= !(drive && !analog);
						pad_out[N]         <= muxed ? periph_out_in[N] : out_reg[g][p];
						pad_in_en_out[N]   <= muxed ? !analog : cfg[CFG_INPUT_BUFFER_ENABLE];
						pad_pull_en_out[N] <= cfg[CFG_PULL_ENABLE] && !drive && !analog;
						pad_pull_up_out[N] <= out_reg[g][p];
						periph_level_out[N] <= pad_level_in[N];
					end
				end
			end
		end
	endgenerate

	assign periph_function_select_out = pmux_reg;
	assign rd_word = (grp_ok && local_ok) ? rd_grp[32'(acc_grp) % GROUPS] : '0;

	// ==========================================================================
	// Bridge sequencing and read data
	always_comb begin
		bstate_next = bstate_reg;
		case (bstate_reg)
			B_IDLE:
				if (bridge_valid_in && !local_valid_in)
					bstate_next = need_demand ? B_WAIT : B_DONE;
			B_WAIT:
				if (bridge_go)
					bstate_next = B_DONE;
			B_DONE:
				bstate_next = B_IDLE;
			default:
				bstate_next = B_IDLE;
		endcase
	end

	assign bridge_ready_out = bstate_reg == B_DONE;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			bstate_reg <= B_IDLE;
			cnt_reg    <= '0;
		end else begin
			bstate_reg <= bstate_next;
			cnt_reg    <= (bstate_reg != B_WAIT) ? 2'h0 :
				(32'(cnt_reg) < SYNC_STAGES) ? cnt_reg + 2'h1 : cnt_reg;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			local_rdata_out  <= '0;
			bridge_rdata_out <= '0;
		end else begin
			if (local_valid_in && !local_write_in)
				local_rdata_out <= rd_word;
			if (bridge_go && !bridge_write_in)
				bridge_rdata_out <= rd_word;
		end
	end

	// ==========================================================================
	// Checks
	logic [PIN_W-1:0] dir0;
	logic [PIN_W-1:0] out0;
	logic             we0;
	assign dir0 = dir_reg[0];
	assign out0 = out_reg[0];
	assign we0  = acc_we && acc_grp == '0;

	sequence s_demand_start;
		bstate_reg == B_IDLE && bridge_valid_in && !local_valid_in && need_demand;
	endsequence
	sequence s_sync_wait;
		!bridge_ready_out [*2] ##[1:8] bridge_ready_out;
	endsequence
	sequence s_quiet_wait;
		!local_valid_in [*2];
	endsequence

	AST_RESET_PINS: assert property (@(posedge clk_sys_in) !rst_n_in |=>
		(&pad_oe_n_out) && !(|pad_in_en_out) && !(|pad_pull_en_out))
		else $error("pins not disabled after reset");
	AST_LOCAL_WINS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		local_valid_in && bstate_reg == B_IDLE |=> !bridge_ready_out)
		else $error("bridge served during local access");
	AST_BRIDGE_ONE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		bstate_reg == B_IDLE && bridge_valid_in && !local_valid_in && !need_demand
		|=> bridge_ready_out)
		else $error("bridge answer late");
	AST_DEMAND_READ: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		s_demand_start |=> s_sync_wait)
		else $error("demand read timing wrong");
	AST_DEMAND_TWO: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		s_demand_start ##1 s_quiet_wait |=> bridge_ready_out)
		else $error("demand read not two cycles late");
	AST_DIR_SET: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		we0 && acc_off == OFF_DIR + VIEW_SET |=> dir0 == ($past(dir0) | $past(acc_bits)))
		else $error("direction set view wrong");
	AST_OUT_TGL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		we0 && acc_off == OFF_OUT + VIEW_TGL |=> out0 == ($past(out0) ^ $past(acc_bits)))
		else $error("output toggle view wrong");
	AST_WP_BLOCK: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		acc_go && acc.wr && wp_in && !(bridge_go && bridge_debug_in)
		|=> $stable(dir0) && $stable(out0))
		else $error("protected write took effect");
	AST_NO_PULL_OUT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(pad_pull_en_out & ~pad_oe_n_out) == '0)
		else $error("pull on a driven pin");
	AST_ANALOG_OFF: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		per_pin_config_reg[8][CFG_PERIPH_MUX_ENABLE] && periph_analog_in[8]
		|=> pad_oe_n_out[8] && !pad_in_en_out[8] && !pad_pull_en_out[8])
		else $error("analog pin keeps digital features");
	AST_DRIVE_LEVEL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		dir0[0] && !per_pin_config_reg[0][CFG_PERIPH_MUX_ENABLE]
		|=> !pad_oe_n_out[0] && pad_out[0] == $past(out0[0]))
		else $error("output pin not driven with output bit");
endmodule : iopgc_top

// ===== testbench/iopgc_pad_model.sv
// Pad world model: resolves every pad level from controller drive, pulls and outside drivers
`timescale 1ns/100ps
module iopgc_pad_model #(
	parameter int NP = 64
) (
	input  wire logic          clk_sys_in,
	input  wire logic [NP-1:0] pad_drive_in,
	input  wire logic [NP-1:0] pad_oe_n_in,
	input  wire logic [NP-1:0] pull_en_in,
	input  wire logic [NP-1:0] pull_up_in,
	input  wire logic [NP-1:0] ext_drive_in,
	input  wire logic [NP-1:0] ext_level_in,
	output logic      [NP-1:0] pad_level_out
);
	logic [NP-1:0] float_reg = '0;
	// ==========================================================================
	// Undriven pads without pull wander every cycle
	always @(posedge clk_sys_in) begin
		float_reg <= ~float_reg;
	end
	// ==========================================================================
	// Controller drive wins, then outside driver, then pull
	always_comb begin
		for (int n = 0; n < NP; n++) begin
			if (!pad_oe_n_in[n])
				pad_level_out[n] = pad_drive_in[n];
			else if (ext_drive_in[n])
				pad_level_out[n] = ext_level_in[n];
			else if (pull_en_in[n])
				pad_level_out[n] = pull_up_in[n];
			else
				pad_level_out[n] = float_reg[n];
		end
	end
endmodule : iopgc_pad_model

// ===== testbench/iopgc_top_tb.sv
// Self-checking bench for the I/O pin group controller
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module iopgc_top_tb;
	import iopgc_pkg::*;
	localparam int NP = 2 * PIN_W;
	logic                 clk_sys_in, rst_n_in, wp_in, local_valid_in, local_write_in;
	logic                 bridge_valid_in, bridge_write_in, bridge_debug_in, bridge_ready_out;
	logic [ADDR_W-1:0]    local_addr_in, bridge_addr_in, ad;
	logic [1:0]           local_size_in, sz, bo;
	logic [LANES-1:0]     bridge_be_in;
	logic [PIN_W-1:0]     local_wdata_in, local_rdata_out, bridge_wdata_in, bridge_rdata_out;
	logic [NP-1:0]        pad_level_in, pad_out, pad_oe_n_out, pad_in_en_out, pad_pull_en_out;
	logic [NP-1:0]        pad_pull_up_out, periph_out_in, periph_oe_in, periph_analog_in;
	logic [NP-1:0]        periph_level_out, ext_drive, ext_level;
	logic [NP*FSEL_W-1:0] fsel;
	logic [PIN_W-1:0]     lq[$], bq[$], dir_m[2], out_m[2], wd;
	logic                 lrd_q;
	int                   miscompares, n_checks, lat;
	// ==========================================================================
	// Design and pad world
	iopgc_top #(.GROUPS(2)) u_iopgc_top (.clk_sys_in, .rst_n_in, .wp_in, .local_valid_in,
		.local_write_in, .local_addr_in, .local_size_in, .local_wdata_in, .local_rdata_out,
		.bridge_valid_in, .bridge_write_in, .bridge_debug_in, .bridge_addr_in, .bridge_be_in,
		.bridge_wdata_in, .bridge_rdata_out, .bridge_ready_out, .pad_level_in, .pad_out,
		.pad_oe_n_out, .pad_in_en_out, .pad_pull_en_out, .pad_pull_up_out, .periph_out_in,
		.periph_oe_in, .periph_analog_in, .periph_level_out, .periph_function_select_out(fsel));
	iopgc_pad_model #(.NP(NP)) u_iopgc_pad_model (.clk_sys_in, .pad_drive_in(pad_out),
		.pad_oe_n_in(pad_oe_n_out), .pull_en_in(pad_pull_en_out), .pull_up_in(pad_pull_up_out),
		.ext_drive_in(ext_drive), .ext_level_in(ext_level), .pad_level_out(pad_level_in));
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	// ==========================================================================
	// Read result monitor
	always @(posedge clk_sys_in) lrd_q <= local_valid_in && !local_write_in;
	always @(negedge clk_sys_in) begin
		if (lrd_q && lq.size() > 0) `CHK(local_rdata_out, lq.pop_front())
		if (bridge_ready_out && !bridge_write_in && bq.size() > 0)
			`CHK(bridge_rdata_out, bq.pop_front())
	end
	// ==========================================================================
	// Reference model of the direction and output registers
	function automatic logic [PIN_W-1:0] upd(logic [PIN_W-1:0] o, logic [1:0] v,
		logic [PIN_W-1:0] d, logic [LANES-1:0] be);
		logic [PIN_W-1:0] bm;
		bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		case (v)
			2'h0: upd = (o & ~bm) | (d & bm);
			2'h1: upd = o & ~(d & bm);
			2'h2: upd = o | (d & bm);
			default: upd = o ^ (d & bm);
		endcase
	endfunction : upd
	task automatic mdl(input logic [ADDR_W-1:0] a, input logic [PIN_W-1:0] d,
		input logic [LANES-1:0] be);
		if (a[6:5] == 2'h0 && a[9:8] == 2'h0) begin
			if (a[4]) out_m[a[7]] = upd(out_m[a[7]], a[3:2], d, be);
			else dir_m[a[7]] = upd(dir_m[a[7]], a[3:2], d, be);
		end
	endtask : mdl
	// ==========================================================================
	// Bus tasks
	task automatic lb(input logic w, input logic [ADDR_W-1:0] a, input logic [1:0] s,
		input logic [PIN_W-1:0] d, input logic [PIN_W-1:0] e);
		logic [LANES-1:0] be;
		be = (s == SIZE_BYTE) ? BE_ONE << a[1:0] : (s == SIZE_HALF) ? BE_LO << a[1:0] : BE_ALL;
		if (!w) lq.push_back(e);
		else if (!wp_in) mdl(a, d, be);
		{local_valid_in, local_write_in, local_addr_in, local_size_in} = {1'b1, w, a, s};
		local_wdata_in = d;
		@(negedge clk_sys_in);
	endtask : lb
	task automatic idle(input int n);
		local_valid_in = 1'b0;
		repeat (n) @(negedge clk_sys_in);
	endtask : idle
	task automatic br(input logic w, input logic dbg, input logic [ADDR_W-1:0] a,
		input logic [LANES-1:0] be, input logic [PIN_W-1:0] d, input logic [PIN_W-1:0] e,
		output int n);
		if (!w) bq.push_back(e);
		else if (!wp_in || dbg) mdl(a, d, be);
		{bridge_valid_in, bridge_write_in, bridge_debug_in, bridge_addr_in} = {1'b1, w, dbg, a};
		{bridge_be_in, bridge_wdata_in} = {be, d};
		n = 0;
		do begin
			@(negedge clk_sys_in);
			n++;
		end while (bridge_ready_out !== 1'b1 && n < 50);
		if (bridge_ready_out !== 1'b1)
			miscompares++;
		@(negedge clk_sys_in);
		bridge_valid_in = 1'b0;
		@(negedge clk_sys_in);
	endtask : br
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	// ==========================================================================
	// Main sequence
	initial begin
		wd = $urandom(32'h2e19);
		{rst_n_in, wp_in, local_valid_in, local_write_in, local_addr_in, local_size_in} = '0;
		{bridge_valid_in, bridge_write_in, bridge_debug_in, bridge_addr_in, bridge_be_in} = '0;
		{local_wdata_in, bridge_wdata_in, ext_drive, ext_level} = '0;
		{periph_out_in, periph_oe_in, periph_analog_in} = '0;
		dir_m = '{default: '0};
		out_m = '{default: '0};
		fork
			begin
				#20000;
				miscompares++;
				end_sim();
			end
		join_none
		repeat (6) @(negedge clk_sys_in);
		`CHK(pad_oe_n_out, {NP{1'b1}})
		`CHK({pad_in_en_out, pad_pull_en_out, pad_out}, {3*NP{1'b0}})
		rst_n_in = 1'b1;
		@(negedge clk_sys_in);
		for (int i = 0; i < 64; i++) begin
			wp_in = (i % 7 == 6);
			sz = 2'($urandom % 3);
			bo = 2'($urandom) & ((sz == 2'h2) ? 2'h0 : (sz == 2'h1) ? 2'h2 : 2'h3);
			ad = {2'h0, i[0], 2'h0, i[3], i[2:1], bo};
			lb(1'b1, ad, sz, $urandom, '0);
			lb(1'b0, ad & 10'h390, 2'h2, '0, ad[4] ? out_m[ad[7]] : dir_m[ad[7]]);
		end
		wp_in = 1'b0;
		lb(1'b1, 10'h000, 2'h2, 32'h1, '0);
		lb(1'b1, 10'h010, 2'h2, 32'h201, '0);
		idle(2);
		`CHK({pad_oe_n_out[1:0], pad_out[0]}, 3'b101)
		ext_drive = 64'h1_0000_00fe;
		ext_level = 64'h1_0000_00fa;
		br(1'b1, 1'b0, 10'h040, 4'hf, 32'h02020202, '0, lat);
		br(1'b1, 1'b0, 10'h024, 4'h1, 32'hf, '0, lat);
		idle(4);
		lb(1'b0, 10'h020, 2'h2, '0, 32'h0000000b);
		idle(1);
		`CHK(pad_in_en_out[7:0], 8'h0f)
		br(1'b0, 1'b0, 10'h024, 4'hf, '0, 32'hf, lat);
		`CHK(lat, 1)
		br(1'b1, 1'b0, 10'h0c0, 4'h1, 32'h2, '0, lat);
		br(1'b0, 1'b0, 10'h0a0, 4'hf, '0, 32'h1, lat);
		`CHK(lat, 3)
		br(1'b0, 1'b0, 10'h100, 4'hf, '0, '0, lat);
		fork
			begin
				lb(1'b0, 10'h000, 2'h2, '0, dir_m[0]);
				local_valid_in = 1'b0;
			end
			br(1'b0, 1'b0, 10'h010, 4'hf, '0, out_m[0], lat);
		join
		`CHK(lat, 2)
		wp_in = 1'b1;
		br(1'b1, 1'b0, 10'h080, 4'hf, 32'hffffffff, '0, lat);
		br(1'b1, 1'b1, 10'h080, 4'hf, 32'h5a5a0f0f, '0, lat);
		wp_in = 1'b0;
		lb(1'b0, 10'h080, 2'h2, '0, dir_m[1]);
		idle(1);
		br(1'b1, 1'b0, 10'h048, 4'h3, 32'h0401, '0, lat);
		br(1'b1, 1'b0, 10'h034, 4'h1, 32'h5, '0, lat);
		periph_oe_in[8] = 1'b1;
		periph_out_in[8] = 1'b1;
		idle(3);
		`CHK({pad_oe_n_out[8], pad_out[8], periph_level_out[8]}, 3'b011)
		`CHK(fsel[8*FSEL_W +: FSEL_W], 4'h5)
		`CHK({pad_pull_en_out[9], pad_pull_up_out[9]}, 2'b11)
		lb(1'b1, 10'h008, SIZE_HALF, 32'h0200, '0);
		idle(3);
		`CHK({pad_pull_en_out[9], pad_oe_n_out[9], pad_out[9]}, 3'b001)
		periph_analog_in[8] = 1'b1;
		idle(3);
		`CHK({pad_oe_n_out[8], pad_in_en_out[8], pad_pull_en_out[8]}, 3'b100)
		end_sim();
	end
endmodule : iopgc_top_tb
